// >>> rtl/dcps_defines.svh
// register offsets, field positions and reset values of the control/pin-status group
// assumes: included by the package, the checker and the bench
`ifndef DCPS_DEFINES_SVH
`define DCPS_DEFINES_SVH
`define DCPS_ADDR_W       8
`define DCPS_DATA_W       16
`define DCPS_OFS_CTRL     8'h18
`define DCPS_OFS_TADDR    8'h1a
`define DCPS_OFS_LEVEL    8'h20
`define DCPS_OFS_FLAGS    8'h22
`define DCPS_OFS_MASK     8'h24
`define DCPS_BIT_SRST     0
`define DCPS_BIT_COMMIT   1
`define DCPS_BIT_CFGD     2
`define DCPS_BIT_FMP      3
`define DCPS_BIT_GCALL    5
`define DCPS_FMP_RST      1'h1
`define DCPS_ALT_LO       9
`define DCPS_TADDR_W      7
`define DCPS_TOP_PIN_IRQ  1
`define DCPS_TOP_READY    12
`define DCPS_CFG_FALL     5
`define DCPS_CFG_RISE     4
`define DCPS_PINS         16
`define DCPS_WARM_W       3   // sync stages plus previous sample after reset
`endif

// >>> rtl/dcps_pkg.sv
// types shared by both ends of the control/pin-status register group
// assumes: dcps_defines.svh on the include path
`include "dcps_defines.svh"
package dcps_pkg;
  typedef logic [`DCPS_ADDR_W-1:0] dcps_addr_t;
  typedef logic [`DCPS_DATA_W-1:0] dcps_data_t;
  typedef enum logic [1:0]
  {
    DCPS_IDLE   = 2'b00,
    DCPS_WAIT   = 2'b01,
    DCPS_DONE   = 2'b10
  } dcps_host_st_t;
endpackage

// >>> rtl/dcps_if.sv
// management access channel between host and device register group
// assumes: one clock mclk, single-cycle access, read data valid next cycle
`timescale 1ns/1ps
interface dcps_if;
  import dcps_pkg::*;
  logic       req;     // access strobe, one cycle
  logic       wr;      // 1 write, 0 read
  dcps_addr_t addr;
  dcps_data_t wdata;
  dcps_data_t rdata;
  logic       ack;     // answer pulse one cycle after req
  logic       irq;     // pin-change interrupt level
  modport host (output req, output wr, output addr, output wdata,
                input rdata, input ack, input irq);
  modport dev  (input req, input wr, input addr, input wdata,
                output rdata, output ack, output irq);
endinterface

// >>> rtl/dcps_device.sv
// device end: control, target address, pin level, pin-change flag and mask registers
// assumes: pins synchronous in source domain only loosely; synchronised here
`timescale 1ns/1ps
module dcps_device #(
  parameter int NPINS = `DCPS_PINS
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  dcps_if.dev                      bus,
  input  wire logic [NPINS-1:0]    pin_in,            // raw general_pin levels
  input  wire logic [NPINS-1:0]    rise_sel,          // rising_edge_alert per pin
  input  wire logic [NPINS-1:0]    fall_sel,          // falling_edge_alert per pin
  input  wire logic [NPINS-1:0]    pin_override_enable,
  input  wire logic [7:0]          staged_cfg [NPINS],
  input  wire logic                config_done,       // full configuration finished
  input  wire logic [6:0]          strap_address,
  input  wire logic                otp_address_override_enable,
  input  wire logic [6:0]          otp_address_value,
  input  wire logic                standalone_mode,
  input  wire logic                general_call_seen, // general call address observed
  output logic [7:0]               live_cfg [NPINS],
  output logic                     commit_done,
  output logic                     general_call_ack,
  output logic                     fast_mode_plus_select,
  output logic [6:0]               target_address,
  output logic                     soft_chip_reset,
  output logic [NPINS-1:0]         alt_function_sel,
  output logic [15:0]              top_irq_bits
);
  import dcps_pkg::*;

  // ****************************************************************
  // synchroniser and edge detection
  // ****************************************************************
  logic [NPINS-1:0] sync1_reg, sync2_reg, prev_reg;
  logic [`DCPS_WARM_W-1:0] warm_reg;  // fills with ones after reset release
  logic [NPINS-1:0] flags_reg, flags_next, mask_reg;
  logic             gcall_reg, fmp_reg, cfgd_reg, commit_reg, srst_reg;
  logic [6:0]       taddr_reg;
  logic             addr_loaded_reg;
  logic             ack_reg, irq_reg;
  dcps_data_t       rdata_reg;

  // two-stage pin synchroniser; first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
      warm_reg  <= '0;
    end
    else
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
      warm_reg  <= {warm_reg[`DCPS_WARM_W-2:0], 1'b1};
    end
  end

  // qualified edges per pin
  wire [NPINS-1:0] rise_ev = sync2_reg & ~prev_reg & rise_sel;
  wire [NPINS-1:0] fall_ev = ~sync2_reg & prev_reg & fall_sel;
  // no edges until prev holds a real pin sample, else a pin high at reset fakes a rise
  wire             edge_ok   = warm_reg[`DCPS_WARM_W-1];
  wire [NPINS-1:0] change_ev = edge_ok ? (rise_ev | fall_ev) : '0;

  // ****************************************************************
  // register decode
  // ****************************************************************
  // write strobe for one register offset
  function automatic logic wr_hit(input logic       req,
                                  input logic       wr,
                                  input dcps_addr_t a,
                                  input dcps_addr_t ofs);
    return req && wr && a == ofs;
  endfunction

  wire wr_ctrl  = wr_hit(bus.req, bus.wr, bus.addr, `DCPS_OFS_CTRL);
  wire wr_taddr = wr_hit(bus.req, bus.wr, bus.addr, `DCPS_OFS_TADDR);
  wire wr_flags = wr_hit(bus.req, bus.wr, bus.addr, `DCPS_OFS_FLAGS);
  wire wr_mask  = wr_hit(bus.req, bus.wr, bus.addr, `DCPS_OFS_MASK);
  wire rd       = bus.req && !bus.wr;
  wire ovr_pending = |pin_override_enable;
  wire commit_go   = commit_reg && !ovr_pending;

  // set wins over write-one clear
  assign flags_next = (flags_reg & ~(wr_flags ? bus.wdata[NPINS-1:0] : '0))
                      | change_ev;

  // read mux; reserved bits zero
  dcps_data_t rd_mux;
  wire dcps_data_t ctrl_rd = dcps_data_t'({gcall_reg, 1'b0, fmp_reg, cfgd_reg,
                                           commit_reg, 1'b0});
  assign rd_mux = (bus.addr == `DCPS_OFS_CTRL)  ? ctrl_rd :
                  (bus.addr == `DCPS_OFS_TADDR) ? dcps_data_t'(taddr_reg) :
                  (bus.addr == `DCPS_OFS_LEVEL) ? dcps_data_t'(sync2_reg) :
                  (bus.addr == `DCPS_OFS_FLAGS) ? dcps_data_t'(flags_reg) :
                  (bus.addr == `DCPS_OFS_MASK)  ? dcps_data_t'(mask_reg) : '0;

  // ****************************************************************
  // control register
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gcall_reg  <= 1'b0;
      fmp_reg    <= `DCPS_FMP_RST;
      cfgd_reg   <= 1'b0;
      commit_reg <= 1'b0;
      srst_reg   <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        gcall_reg <= bus.wdata[`DCPS_BIT_GCALL];
        fmp_reg   <= bus.wdata[`DCPS_BIT_FMP];
      end
      if (config_done)
        cfgd_reg <= 1'b1;
      if (commit_go)
        commit_reg <= 1'b0;
      else if (wr_ctrl && bus.wdata[`DCPS_BIT_COMMIT])
        commit_reg <= 1'b1;
      srst_reg <= wr_ctrl && bus.wdata[`DCPS_BIT_SRST];
    end
  end

  // target address: loaded once after reset release, then writable
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      taddr_reg       <= '0;
      addr_loaded_reg <= 1'b0;
    end
    else if (!addr_loaded_reg)
    begin
      taddr_reg       <= otp_address_override_enable ? otp_address_value
                                                     : strap_address;
      addr_loaded_reg <= 1'b1;
    end
    else if (wr_taddr)
      taddr_reg <= bus.wdata[`DCPS_TADDR_W-1:0];
  end

  // ****************************************************************
  // flags, mask, bus answer, interrupt
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_reg <= '0;
      mask_reg  <= '0;
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
      irq_reg   <= 1'b0;
    end
    else
    begin
      flags_reg <= flags_next;
      if (wr_mask)
        mask_reg <= bus.wdata[NPINS-1:0];
      ack_reg   <= bus.req;
      if (rd)
        rdata_reg <= rd_mux;
      irq_reg   <= |(flags_next & mask_reg);
    end
  end

  // live pin configuration, all pins copied in one edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NPINS; i++)
        live_cfg[i] <= '0;
      commit_done <= 1'b0;
    end
    else
    begin
      if (commit_go)
        live_cfg <= staged_cfg;
      commit_done <= commit_go;
    end
  end

  // derived outputs, each registered
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      general_call_ack      <= 1'b0;
      fast_mode_plus_select <= `DCPS_FMP_RST;
      target_address        <= '0;
      soft_chip_reset       <= 1'b0;
      alt_function_sel      <= '0;
      top_irq_bits          <= '0;
    end
    else
    begin
      general_call_ack      <= general_call_seen && gcall_reg;
      fast_mode_plus_select <= fmp_reg;
      target_address        <= taddr_reg;
      soft_chip_reset       <= srst_reg;
      for (int i = 0; i < NPINS; i++)
        alt_function_sel[i] <= standalone_mode && i >= `DCPS_ALT_LO;
      top_irq_bits <= '0;
      top_irq_bits[`DCPS_TOP_PIN_IRQ] <= |(flags_next & mask_reg);
      top_irq_bits[`DCPS_TOP_READY]   <= cfgd_reg;
    end
  end

  assign bus.ack   = ack_reg;
  assign bus.rdata = rdata_reg;
  assign bus.irq   = irq_reg;
endmodule

// >>> rtl/dcps_host.sv
// host end: issues single register accesses and returns read data
// assumes: one access in flight; also holds output-only pins low through reset
`timescale 1ns/1ps
module dcps_host (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  dcps_if.host                     bus,
  input  wire logic                cmd_valid,
  input  wire logic                cmd_write,
  input  wire dcps_pkg::dcps_addr_t cmd_addr,
  input  wire dcps_pkg::dcps_data_t cmd_wdata,
  output logic                     cmd_ready,
  output logic                     resp_valid,
  output dcps_pkg::dcps_data_t     resp_data,
  output logic                     irq_out,
  output logic                     output_only_pin_a,
  output logic                     output_only_pin_b
);
  import dcps_pkg::*;

  // ****************************************************************
  // access sequencer
  // ****************************************************************
  dcps_host_st_t st_reg;
  logic          req_reg, wr_reg;
  dcps_addr_t    addr_reg;
  dcps_data_t    wdata_reg;

  wire take = (st_reg == DCPS_IDLE) && cmd_valid;

  // one access at a time, wait for the answer
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg     <= DCPS_IDLE;
      req_reg    <= 1'b0;
      wr_reg     <= 1'b0;
      addr_reg   <= '0;
      wdata_reg  <= '0;
      resp_valid <= 1'b0;
      resp_data  <= '0;
      cmd_ready  <= 1'b0;
    end
    else
    begin
      req_reg    <= take;
      resp_valid <= 1'b0;
      cmd_ready  <= 1'b0;
      unique case (st_reg)
        DCPS_IDLE:
        begin
          cmd_ready <= !cmd_valid;
          if (take)
          begin
            wr_reg    <= cmd_write;
            addr_reg  <= cmd_addr;
            wdata_reg <= cmd_wdata;
            st_reg    <= DCPS_WAIT;
          end
        end
        DCPS_WAIT:
          if (bus.ack)
          begin
            resp_valid <= 1'b1;
            resp_data  <= bus.rdata;
            st_reg     <= DCPS_DONE;
          end
        DCPS_DONE:
        begin
          cmd_ready <= 1'b1;
          st_reg    <= DCPS_IDLE;
        end
        default:
          st_reg <= DCPS_IDLE;
      endcase
    end
  end

  // output-only pins kept low around reset release
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      output_only_pin_a <= 1'b0;
      output_only_pin_b <= 1'b0;
      irq_out           <= 1'b0;
    end
    else
    begin
      output_only_pin_a <= 1'b0;
      output_only_pin_b <= 1'b0;
      irq_out           <= bus.irq;
    end
  end

  assign bus.req   = req_reg;
  assign bus.wr    = wr_reg;
  assign bus.addr  = addr_reg;
  assign bus.wdata = wdata_reg;
endmodule

// >>> tb/dcps_asserts.sv
// checker for the host/device management channel
// assumes: fed the channel signals by name beside the interface
`timescale 1ns/1ps
`include "dcps_defines.svh"
module dcps_asserts
(
  input wire logic                 mclk,
  input wire logic                 rst_n,
  input wire logic                 req,
  input wire logic                 wr,
  input wire dcps_pkg::dcps_addr_t addr,
  input wire dcps_pkg::dcps_data_t wdata,
  input wire dcps_pkg::dcps_data_t rdata,
  input wire logic                 ack,
  input wire logic                 irq
);
  import dcps_pkg::*;
  dcps_data_t mask_q;
  // ************
  // helper state
  // ************
  // shadow of the last mask written
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n) mask_q <= 16'h0000;
    else if (req && wr && addr == `DCPS_OFS_MASK) mask_q <= wdata;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // read of one offset, answered next cycle
  sequence rd_s(a);
    req && !wr && addr == a ##1 ack;
  endsequence
  sequence rd_gap_s;
    req && !wr && !(addr inside {`DCPS_OFS_CTRL, `DCPS_OFS_TADDR, `DCPS_OFS_LEVEL,
      `DCPS_OFS_FLAGS, `DCPS_OFS_MASK}) ##1 ack;
  endsequence
  // **********
  // assertions
  // **********
  ctrl_srst_zero_a: assert property (rd_s(`DCPS_OFS_CTRL) |-> !rdata[0])
    else $error("reset bit reads one");
  ctrl_reserved_a: assert property (rd_s(`DCPS_OFS_CTRL) |->
    rdata[15:6] == 10'h000 && !rdata[4]) else $error("reserved control bits set");
  taddr_top_a: assert property (rd_s(`DCPS_OFS_TADDR) |-> rdata[15:7] == 9'h000)
    else $error("address top bits set");
  unmapped_zero_a: assert property (rd_gap_s |-> rdata == 16'h0000)
    else $error("unmapped read not zero");
  mask_readback_a: assert property (rd_s(`DCPS_OFS_MASK) |-> rdata == mask_q)
    else $error("mask readback wrong");
  irq_needs_mask_a: assert property (irq |->
    mask_q != 16'h0000 || $past(mask_q) != 16'h0000) else $error("irq with mask clear");
  irq_drops_a: assert property (req && wr && addr == `DCPS_OFS_MASK &&
    wdata == 16'h0000 |-> ##3 !irq) else $error("irq stays after mask clear");
  irq_flags_a: assert property (rd_s(`DCPS_OFS_FLAGS) ##0 (|(rdata & mask_q)) |-> irq)
    else $error("irq low with enabled flag set");
endmodule

// >>> tb/dcps_test.sv
// bench: host end drives the device end; checks by register access and at the device and host outputs
// assumes: rtl package, interface and both ends compiled first
`timescale 1ns/1ps
`include "dcps_defines.svh"
module dcps_test;
  import dcps_pkg::*;
  localparam dcps_addr_t ct = `DCPS_OFS_CTRL, ta = `DCPS_OFS_TADDR, lv = `DCPS_OFS_LEVEL;
  localparam dcps_addr_t fl = `DCPS_OFS_FLAGS, mk = `DCPS_OFS_MASK;
  logic       mclk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0, config_done = 1'b0;
  logic       otp_address_override_enable = 1'b0, standalone_mode = 1'b0, general_call_seen = 1'b0;
  logic       cmd_ready, resp_valid, irq_out, output_only_pin_a, output_only_pin_b;
  logic       commit_done, general_call_ack, fast_mode_plus_select, soft_chip_reset;
  dcps_addr_t cmd_addr = 8'h00;
  dcps_data_t cmd_wdata = 16'h0000, pin_in = 16'h8421, rise_sel = 16'h0000, fall_sel = 16'h0000;
  dcps_data_t pin_override_enable = 16'h0000, resp_data, alt_function_sel, top_irq_bits;
  logic [6:0] strap_address = 7'h2b, otp_address_value = 7'h51, target_address;
  logic [7:0] staged_cfg [16], live_cfg [16];
  int         n_fail = 0, comparisons = 0, n_srst = 0, n_done = 0;
  // *********
  // structure
  // *********
  dcps_if bus_if ();
  dcps_host dcps_host_i (.mclk, .rst_n, .bus(bus_if), .cmd_valid, .cmd_write, .cmd_addr,
    .cmd_wdata, .cmd_ready, .resp_valid, .resp_data, .irq_out, .output_only_pin_a,
    .output_only_pin_b);
  dcps_device dcps_device_i (.mclk, .rst_n, .bus(bus_if), .pin_in, .rise_sel, .fall_sel,
    .pin_override_enable, .staged_cfg, .config_done, .strap_address,
    .otp_address_override_enable, .otp_address_value, .standalone_mode, .general_call_seen,
    .live_cfg, .commit_done, .general_call_ack, .fast_mode_plus_select, .target_address,
    .soft_chip_reset, .alt_function_sel, .top_irq_bits);
  dcps_asserts dcps_asserts_i (.mclk, .rst_n, .req(bus_if.req), .wr(bus_if.wr),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .ack(bus_if.ack),
    .irq(bus_if.irq));
  // clock and pulse counters
  always #12.5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    n_srst += soft_chip_reset;
    n_done += commit_done;
  end
  // *****
  // tasks
  // *****
  task give_verdict;
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input dcps_data_t s, input dcps_data_t e);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  // one access through the host end, bounded waits
  task acc(input logic w, input dcps_addr_t a, input dcps_data_t d);
    int i;
    for (i = 0; i < 20 && cmd_ready !== 1'b1; i++) @(posedge mclk) #2;
    if (i == 20)
    begin
      n_fail++;
      give_verdict;
    end
    {cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {1'b1, w, a, d};
    @(posedge mclk) #2 cmd_valid = 1'b0;
    for (i = 0; i < 20 && resp_valid !== 1'b1; i++) @(posedge mclk) #2;
    if (i == 20)
    begin
      n_fail++;
      give_verdict;
    end
  endtask
  task rd(input string n, input dcps_addr_t a, input dcps_data_t e);
    acc(1'b0, a, 16'h0000);
    chk(n, resp_data, e);
  endtask
  task do_reset;
    rst_n = 1'b0;
    repeat (4) @(posedge mclk);
    #2 rst_n = 1'b1;
    cyc(3);
  endtask
  // ********
  // sequence
  // ********
  initial
  begin
    for (int k = 0; k < 16; k++) staged_cfg[k] = 8'ha5;
    do_reset;
    chk("gpo", 16'({output_only_pin_a, output_only_pin_b}), 16'h0000);
    chk("alt", alt_function_sel, 16'h0000);
    rd("ctrl", ct, 16'h0008);
    rd("taddr", ta, 16'h002b);
    rd("mask", mk, 16'h0000);
    rd("flags", fl, 16'h0000);
    acc(1'b1, lv, 16'h0000);
    rd("level", lv, 16'h8421);
    acc(1'b1, 8'h30, 16'hffff);
    rd("gap", 8'h30, 16'h0000);
    acc(1'b1, ta, 16'h00ff);
    rd("taddr", ta, 16'h007f);
    chk("taddr_out", 16'(target_address), 16'h007f);
    acc(1'b1, ct, 16'hfffc);
    rd("ctrl", ct, 16'h0028);
    general_call_seen = 1'b1;
    cyc(2);
    chk("gcall", 16'(general_call_ack), 16'h0001);
    acc(1'b1, ct, 16'h0000);
    cyc(2);
    chk("gcall", 16'(general_call_ack), 16'h0000);
    chk("fmp", 16'(fast_mode_plus_select), 16'h0000);
    config_done = 1'b1;
    cyc(2);
    rd("ctrl", ct, 16'h0004);
    chk("ready", 16'(top_irq_bits[12]), 16'h0001);
    acc(1'b1, ct, 16'h0001);
    cyc(2);
    chk("srst", 16'(n_srst), 16'h0001);
    pin_override_enable = 16'h0004;
    acc(1'b1, ct, 16'h0002);
    cyc(4);
    rd("ctrl", ct, 16'h0006);
    chk("live", 16'(live_cfg[3]), 16'h0000);
    pin_override_enable = 16'h0000;
    cyc(4);
    chk("live", 16'(live_cfg[15]), 16'h00a5);
    chk("done", 16'(n_done), 16'h0001);
    rd("ctrl", ct, 16'h0004);
    rise_sel = 16'h0001;
    fall_sel = 16'h0002;
    pin_in[1] = 1'b1;
    cyc(5);
    rd("flags", fl, 16'h0000);
    pin_in[1] = 1'b0;
    cyc(5);
    rd("flags", fl, 16'h0002);
    chk("irq", 16'(irq_out), 16'h0000);
    acc(1'b1, mk, 16'h0002);
    rd("mask", mk, 16'h0002);
    chk("irq", 16'(irq_out), 16'h0001);
    chk("top", 16'(top_irq_bits[1]), 16'h0001);
    acc(1'b1, fl, 16'h0000);
    rd("flags", fl, 16'h0002);
    acc(1'b1, fl, 16'h0002);
    rd("flags", fl, 16'h0000);
    chk("top", 16'(top_irq_bits[1]), 16'h0000);
    pin_in[1:0] = 2'b10;
    cyc(5);
    pin_in[1:0] = 2'b01;
    cyc(5);
    rd("flags", fl, 16'h0003);
    acc(1'b1, mk, 16'h0000);
    cyc(2);
    chk("irq", 16'(irq_out), 16'h0000);
    standalone_mode = 1'b1;
    cyc(2);
    chk("alt", alt_function_sel, 16'hfe00);
    otp_address_override_enable = 1'b1;
    do_reset;
    rd("taddr", ta, 16'h0051);
    rd("flags", fl, 16'h0000);
    give_verdict;
  end
endmodule
